// File: src/sbc_colorizer.sv
// Sample stream to spectrum, hit-count grid and colour bitmap, AXI4-Lite controlled.
//
// The register addresses and the AXI4-Lite register port are this design's own decisions.
`timescale 1ns/1ps
module sbc_colorizer
    import sbc_pkg::*;
#(
    parameter int FRAME_CYCLES = FRAME_CYC
) (
    input wire logic aclk,
    input wire logic aresetn,
    input wire logic [7:0] s_axi_awaddr,
    input wire logic s_axi_awvalid,
    output logic s_axi_awready,
    input wire logic [31:0] s_axi_wdata,
    input wire logic [3:0] s_axi_wstrb,
    input wire logic s_axi_wvalid,
    output logic s_axi_wready,
    output logic [1:0] s_axi_bresp,
    output logic s_axi_bvalid,
    input wire logic s_axi_bready,
    input wire logic [7:0] s_axi_araddr,
    input wire logic s_axi_arvalid,
    output logic s_axi_arready,
    output logic [31:0] s_axi_rdata,
    output logic [1:0] s_axi_rresp,
    output logic s_axi_rvalid,
    input wire logic s_axi_rready,
    input wire logic [SMP_W-1:0] smp_data,
    input wire logic smp_valid,
    output logic smp_ready,
    output logic pix_valid,
    output sbc_pix_t pix
);
    localparam int PLOT_LIM = 15;

    logic [CNT_W-1:0] grid_r [CELLS];
    logic grid_we;
    logic [7:0] grid_wa;
    logic [CNT_W-1:0] grid_wd;
    sbc_phase_t phase_r, phase_nxt;
    logic [5:0] pos_r, pos_nxt;
    logic hold_v_r, hold_v_nxt;
    logic [3:0] pcol_r, pcol_nxt;
    logic [7:0] cidx_r, cidx_nxt;
    logic [FRM_W-1:0] frm_r, frm_nxt;
    logic [CNT_W-1:0] waves_r, waves_nxt, lastw_r, lastw_nxt;
    logic [CNT_W-1:0] peak_r, peak_nxt, lastpk_r, lastpk_nxt;
    logic [CNT_W-1:0] min_r, min_nxt, max_r, max_nxt, frames_r, frames_nxt;
    logic [5:0] ctrl_r, ctrl_nxt;
    logic auto_r, auto_nxt;
    logic [ACC_W-1:0] acc_r [COLS];
    logic [ACC_W-1:0] acc_nxt [COLS];
    logic [ROW_W-1:0] hold_r [COLS];
    logic [ROW_W-1:0] hold_nxt [COLS];
    logic awready_r, awready_nxt, bvalid_r, bvalid_nxt, arready_r, arready_nxt;
    logic rvalid_r, rvalid_nxt;
    logic [1:0] bresp_r, bresp_nxt, rresp_r, rresp_nxt;
    logic [31:0] rdata_r, rdata_nxt;
    logic ready_r, ready_nxt, pixv_r, pixv_nxt;
    sbc_pix_t pix_r, pix_nxt;
    logic [1:0] rbw;
    logic take, rec_last, rec_end, plotting, frame_end, conv_last, wr_hit;
    logic [ACC_W-1:0] smp_ext;
    logic [CNT_W-1:0] cur_cnt, eff_max, span;
    logic [CNT_W+2:0] quo;

    assign rbw = ctrl_r[C_RBW +: 2];
    assign smp_ext = {{(ACC_W - SMP_W){smp_data[SMP_W-1]}}, smp_data};
    assign take = smp_valid && ready_r;
    assign rec_last = pos_r == 6'((REC_MIN << rbw) - 1); // [R1]
    assign rec_end = take && rec_last;
    assign plotting = phase_r == PH_RUN && hold_v_r && waves_r < WAVE_MAX; // [R7]
    assign frame_end = frm_r >= FRM_W'(FRAME_CYCLES - 1) || waves_r == WAVE_MAX; // [R7]
    assign conv_last = phase_r == PH_CONV && cidx_r == 8'hFF;
    assign cur_cnt = grid_r[cidx_r];
    assign eff_max = ctrl_r[C_FULL] ? waves_r : max_r; // [R14]
    assign span = eff_max - min_r;
    assign quo = {cur_cnt - min_r, 3'h0} / {3'h0, span}; // [R11]

    // Per-column sequency transform: each sample is added or subtracted by a
    // sign pattern, so every sample of every record is used with no gap.
    for (genvar k = 0; k < COLS; k++) begin : g_col
        logic [ACC_W-1:0] base, sum, mag, shr;
        always_comb begin
            base = (pos_r == '0) ? '0 : acc_r[k];
            sum = (^(pos_r[3:0] & 4'(k))) ? base - smp_ext : base + smp_ext; // [R2]
            mag = sum[ACC_W-1] ? '0 - sum : sum;
            shr = mag >> (MAG_SH + int'(rbw));
            acc_nxt[k] = take ? sum : acc_r[k];
            hold_nxt[k] = hold_r[k];
            if (rec_end) begin
                hold_nxt[k] = (|shr[ACC_W-1:ROW_W]) ? '1 : shr[ROW_W-1:0]; // [R4]
            end
        end
        always_ff @(posedge aclk) begin
            if (!aresetn) begin
                acc_r[k] <= '0;
                hold_r[k] <= '0;
            end else begin
                acc_r[k] <= acc_nxt[k];
                hold_r[k] <= hold_nxt[k];
            end
        end
    end

    // Record cutting, grid plotting, frame timing and colour conversion.
    always_comb begin
        phase_nxt = phase_r;
        pos_nxt = pos_r;
        hold_v_nxt = hold_v_r;
        pcol_nxt = pcol_r;
        cidx_nxt = cidx_r;
        frm_nxt = frm_r;
        waves_nxt = waves_r;
        lastw_nxt = lastw_r;
        peak_nxt = peak_r;
        lastpk_nxt = lastpk_r;
        frames_nxt = frames_r;
        grid_we = 1'b0;
        grid_wa = {pcol_r, hold_r[pcol_r]};
        grid_wd = grid_r[grid_wa] + 16'h0001;
        pixv_nxt = 1'b0;
        pix_nxt = pix_r;
        if (take) begin
            pos_nxt = rec_last ? '0 : pos_r + 6'h01; // [R1]
        end
        if (plotting) begin
            grid_we = 1'b1; // [R5]
            pcol_nxt = pcol_r + 4'h1;
            if (pcol_r == 4'hF) begin
                hold_v_nxt = 1'b0;
                waves_nxt = waves_r + 16'h0001; // [R6]
            end
        end
        // The new record wins over the clear so a spectrum is never lost.
        if (rec_end) begin
            hold_v_nxt = 1'b1; // [R3]
        end
        if (phase_r == PH_RUN) begin
            if (!frame_end) begin
                frm_nxt = frm_r + 22'h000001;
            end else if (!hold_v_r || waves_r == WAVE_MAX) begin
                phase_nxt = PH_CONV; // [R8]
                cidx_nxt = '0;
                peak_nxt = '0;
            end
        end else begin
            grid_we = 1'b1;
            grid_wa = cidx_r;
            grid_wd = '0; // [R17]
            pixv_nxt = 1'b1; // [R8]
            pix_nxt.addr = cidx_r;
            pix_nxt.transp = 1'b0;
            if (cur_cnt == '0 || cur_cnt < min_r) begin
                pix_nxt.rgb = sbc_color(ctrl_r[C_PAL], 4'h0); // [R12]
            end else if (cur_cnt > eff_max || span == '0) begin
                pix_nxt.rgb = sbc_color(ctrl_r[C_PAL], PAL_TOP);
                pix_nxt.transp = cur_cnt > eff_max; // [R13]
            end else begin
                pix_nxt.rgb = sbc_color(ctrl_r[C_PAL], 4'(quo + 1)); // [R10] [R16]
            end
            if (cur_cnt > peak_r) begin
                peak_nxt = cur_cnt;
            end
            cidx_nxt = cidx_r + 8'h01;
            if (conv_last) begin
                phase_nxt = PH_RUN;
                frm_nxt = '0;
                lastw_nxt = waves_r;
                waves_nxt = '0;
                lastpk_nxt = peak_nxt;
                frames_nxt = frames_r + 16'h0001;
            end
        end
        // Stalling the source is the only way to hold a record while the
        // grid is busy; samples are never dropped.
        ready_nxt = ctrl_r[C_EN] && !(hold_v_nxt && pos_nxt == 6'((REC_MIN << rbw) - 1));
    end

    // AXI4-Lite slave: address and data taken together, two-cycle answer.
    always_comb begin
        awready_nxt = s_axi_awvalid && s_axi_wvalid && !awready_r && !bvalid_r;
        arready_nxt = s_axi_arvalid && !arready_r && !rvalid_r;
        bvalid_nxt = bvalid_r && !s_axi_bready;
        rvalid_nxt = rvalid_r && !s_axi_rready;
        bresp_nxt = bresp_r;
        rresp_nxt = rresp_r;
        rdata_nxt = rdata_r;
        ctrl_nxt = ctrl_r;
        min_nxt = min_r;
        max_nxt = max_r;
        auto_nxt = auto_r && !conv_last;
        wr_hit = 1'b0;
        if (conv_last && auto_r) begin
            max_nxt = peak_nxt; // [R15]
        end
        if (awready_r) begin
            bvalid_nxt = 1'b1;
            wr_hit = s_axi_wstrb == 4'hF;
            unique case (s_axi_awaddr)
                A_CTRL: begin
                    if (wr_hit) begin
                        ctrl_nxt = s_axi_wdata[5:0] & ~(6'h01 << C_AUTO);
                        auto_nxt = auto_nxt || s_axi_wdata[C_AUTO];
                    end
                    bresp_nxt = RESP_OK;
                end
                A_MIN: begin
                    if (wr_hit) min_nxt = s_axi_wdata[CNT_W-1:0]; // [R11]
                    bresp_nxt = RESP_OK;
                end
                A_MAX: begin
                    if (wr_hit) max_nxt = s_axi_wdata[CNT_W-1:0]; // [R11]
                    bresp_nxt = RESP_OK;
                end
                default: bresp_nxt = RESP_ERR;
            endcase
        end
        if (arready_r) begin
            rvalid_nxt = 1'b1;
            rresp_nxt = RESP_OK;
            unique case (s_axi_araddr)
                A_CTRL: rdata_nxt = {26'h0, ctrl_r | ({5'h0, auto_r} << C_AUTO)};
                A_MIN: rdata_nxt = {16'h0, min_r};
                A_MAX: rdata_nxt = {16'h0, max_r};
                A_FRAMES: rdata_nxt = {16'h0, frames_r};
                A_PEAK: rdata_nxt = {16'h0, lastpk_r};
                A_WAVES: rdata_nxt = {16'h0, lastw_r};
                default: begin
                    rdata_nxt = '0;
                    rresp_nxt = RESP_ERR;
                end
            endcase
        end
    end

    // Registers of all groups except the column transform; the grid is cleared whole at reset.
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            phase_r <= PH_RUN;
            pos_r <= '0;
            hold_v_r <= 1'b0;
            pcol_r <= '0;
            cidx_r <= '0;
            frm_r <= '0;
            waves_r <= '0;
            lastw_r <= '0;
            peak_r <= '0;
            lastpk_r <= '0;
            frames_r <= '0;
            ctrl_r <= CTRL_RST;
            auto_r <= 1'b0;
            min_r <= MIN_RST;
            max_r <= MAX_RST;
            awready_r <= 1'b0;
            bvalid_r <= 1'b0;
            arready_r <= 1'b0;
            rvalid_r <= 1'b0;
            bresp_r <= RESP_OK;
            rresp_r <= RESP_OK;
            rdata_r <= '0;
            ready_r <= 1'b0;
            pixv_r <= 1'b0;
            pix_r <= '0;
            for (int i = 0; i < CELLS; i++) begin
                grid_r[i] <= '0;
            end
        end else begin
            phase_r <= phase_nxt;
            pos_r <= pos_nxt;
            hold_v_r <= hold_v_nxt;
            pcol_r <= pcol_nxt;
            cidx_r <= cidx_nxt;
            frm_r <= frm_nxt;
            waves_r <= waves_nxt;
            lastw_r <= lastw_nxt;
            peak_r <= peak_nxt;
            lastpk_r <= lastpk_nxt;
            frames_r <= frames_nxt;
            ctrl_r <= ctrl_nxt;
            auto_r <= auto_nxt;
            min_r <= min_nxt;
            max_r <= max_nxt;
            awready_r <= awready_nxt;
            bvalid_r <= bvalid_nxt;
            arready_r <= arready_nxt;
            rvalid_r <= rvalid_nxt;
            bresp_r <= bresp_nxt;
            rresp_r <= rresp_nxt;
            rdata_r <= rdata_nxt;
            ready_r <= ready_nxt;
            pixv_r <= pixv_nxt;
            pix_r <= pix_nxt;
            if (grid_we) begin
                grid_r[grid_wa] <= grid_wd;
            end
        end
    end

    assign s_axi_awready = awready_r;
    assign s_axi_wready = awready_r;
    assign s_axi_bvalid = bvalid_r;
    assign s_axi_bresp = bresp_r;
    assign s_axi_arready = arready_r;
    assign s_axi_rvalid = rvalid_r;
    assign s_axi_rresp = rresp_r;
    assign s_axi_rdata = rdata_r;
    assign smp_ready = ready_r;
    assign pix_valid = pixv_r;
    assign pix = pix_r;

    default clocking cb @(posedge aclk);
    endclocking
    default disable iff (!aresetn);

    sequence s_plot_start;
        $rose(hold_v_r) && plotting;
    endsequence
    sequence s_conv_pixel;
        phase_r == PH_CONV;
    endsequence

    a_plot_bound: assert property (s_plot_start |-> ##[1:PLOT_LIM] pcol_r == 4'hF) // [R9]
        else $error("Spectrum plot took too long.");
    a_cell_incr: assert property (plotting |=> // [R5]
        grid_r[$past(grid_wa)] == $past(grid_r[grid_wa]) + 16'h0001)
        else $error("Grid cell did not count the hit.");
    a_conv_clear: assert property (s_conv_pixel |=> grid_r[$past(cidx_r)] == '0) // [R17]
        else $error("Converted cell was not cleared.");
    a_black_below: assert property (s_conv_pixel and cur_cnt < min_r // [R12]
        |=> pixv_r && pix_r.rgb == 24'h000000)
        else $error("Cell below minimum not black.");
    a_top_transp: assert property (s_conv_pixel and cur_cnt > eff_max // [R13]
        and cur_cnt >= min_r and cur_cnt != '0 |=> pix_r.transp)
        else $error("Cell above maximum not transparent.");
    a_auto_max: assert property (conv_last && auto_r && !awready_r // [R15]
        |=> max_r == lastpk_r && !auto_r)
        else $error("Auto colour did not load the peak.");
    a_wave_cap: assert property (waves_r <= WAVE_MAX) // [R7]
        else $error("Frame exceeded waveform limit.");
    a_rec_hold: assert property (rec_end |=> hold_v_r && pos_r == '0) // [R3]
        else $error("Finished record was not held.");
endmodule

// File: src/sbc_pkg.sv
// Constants, types and palette table for the hit-count histogram colorizer.
// Operation
// [R1] Records cut continuously, length set by bandwidth
// [R2] Transform every record into one spectrum
// [R3] Transforms overlap records, no input gap; code stalls the source while a held spectrum waits for the grid
// [R4] Short events still land, maybe attenuated
// [R5] Each column point increments one grid cell
// [R6] Zero means no hit; columns total N
// [R7] Frames of 50 ms, at most 14,600 waveforms
// [R8] Frame end converts all cells to colours
// [R9] Transform rate above 292,000 per second
// [R10] Example palette black then blue through red
// [R11] Minimum to bottom, maximum to top colour
// [R12] Counts below minimum become black pixels
// [R13] Counts above maximum top hue, transparent
// [R14] Full-scale mode spans zero to total; code spans min_r to total
// [R15] Auto colour sets maximum to peak cell
// [R16] Selectable palette, temperature by default
// [R17] Clear grid after each frame's conversion
package sbc_pkg;
    localparam int COLS = 16;
    localparam int ROW_W = 4;
    localparam int CELLS = 256;
    localparam int CNT_W = 16;
    localparam int SMP_W = 12;
    localparam int ACC_W = 20;
    localparam int FRM_W = 22;
    localparam int REC_MIN = 8;
    localparam int MAG_SH = 10;
    localparam int CLK_HZ = 50_000_000;
    localparam int FRAME_MS = 50;
    localparam int FRAME_CYC = FRAME_MS * (CLK_HZ / 1000);
    localparam int RATE_MIN = 292_000;
    localparam int XFORM_CYC = CLK_HZ / RATE_MIN;
    localparam logic [CNT_W-1:0] WAVE_MAX = 16'h3908;
    localparam logic [7:0] A_CTRL = 8'h00;
    localparam logic [7:0] A_MIN = 8'h04;
    localparam logic [7:0] A_MAX = 8'h08;
    localparam logic [7:0] A_FRAMES = 8'h0C;
    localparam logic [7:0] A_PEAK = 8'h10;
    localparam logic [7:0] A_WAVES = 8'h14;
    localparam int C_EN = 0;
    localparam int C_PAL = 1;
    localparam int C_FULL = 2;
    localparam int C_AUTO = 3;
    localparam int C_RBW = 4;
    localparam logic [5:0] CTRL_RST = 6'h01;
    localparam logic [CNT_W-1:0] MIN_RST = 16'h0001;
    localparam logic [CNT_W-1:0] MAX_RST = 16'h0009;
    localparam logic [3:0] PAL_TOP = 4'h9;
    localparam logic [1:0] RESP_OK = 2'h0;
    localparam logic [1:0] RESP_ERR = 2'h2;
    typedef enum logic [0:0] {PH_RUN, PH_CONV} sbc_phase_t;
    typedef struct packed {
        logic transp;
        logic [23:0] rgb;
        logic [7:0] addr;
    } sbc_pix_t;
    // Palette 0 is the temperature scale, palette 1 a plain grey ramp.
    function automatic logic [23:0] sbc_color(input logic sel, input logic [3:0] idx);
        logic [23:0] c;
        c = 24'h000000;
        if (sel) begin
            c = {idx, idx, idx, idx, idx, idx};
        end else begin
            unique case (idx)
                4'h1: c = 24'h000080;
                4'h2: c = 24'h4080FF;
                4'h3: c = 24'h00FFFF;
                4'h4: c = 24'h00C080;
                4'h5: c = 24'h00FF00;
                4'h6: c = 24'hFFFF00;
                4'h7: c = 24'hFFA500;
                4'h8: c = 24'hFF4500;
                4'h9: c = 24'hC00000;
                default: c = 24'h000000;
            endcase
        end
        return c;
    endfunction
endpackage

// File: test/sbc_src.sv
// Partner model: digitizer stream of zero-valued samples, full or half rate.
`timescale 1ns/1ps
module sbc_src
    import sbc_pkg::*;
(
    input wire logic aclk,
    input wire logic aresetn,
    input wire logic slow,
    input wire logic smp_ready,
    output logic [SMP_W-1:0] smp_data,
    output logic smp_valid
);
    logic ph_r;
    // Valid is held until taken, so in slow mode it may only drop after a transfer.
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            smp_valid <= 1'b0;
            ph_r <= 1'b0;
        end else if (!smp_valid || smp_ready) begin
            ph_r <= ~ph_r;
            smp_valid <= !slow || ph_r;
        end
    end
    // Idle data is the inverse of the payload, so a stale sample is never mistaken for one.
    assign smp_data = smp_valid ? {SMP_W{1'b0}} : {SMP_W{1'b1}};
endmodule

// File: test/tb_top.sv
// Self-checking bench for the colorizer: register access, frames and colour mapping.
`timescale 1ns/1ps
module tb_top
    import sbc_pkg::*;
;
    logic aclk, aresetn, slow;
    logic [7:0] s_axi_awaddr, s_axi_araddr;
    logic s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready;
    logic s_axi_bvalid, s_axi_bready, s_axi_arvalid, s_axi_arready;
    logic s_axi_rvalid, s_axi_rready, smp_valid, smp_ready, pix_valid;
    logic [31:0] s_axi_wdata, s_axi_rdata, w_cnt, peak, rd;
    logic [3:0] s_axi_wstrb;
    logic [1:0] s_axi_bresp, s_axi_rresp;
    logic [SMP_W-1:0] smp_data;
    sbc_pix_t pix;
    logic [24:0] seen [256];
    int failures, checked, pix_idx, frames_seen;

    // A short frame keeps the run small; all expectations follow from it.
    sbc_colorizer #(.FRAME_CYCLES(600)) dut (.aclk, .aresetn, .s_axi_awaddr,
        .s_axi_awvalid, .s_axi_awready, .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid,
        .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready, .s_axi_araddr,
        .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid,
        .s_axi_rready, .smp_data, .smp_valid, .smp_ready, .pix_valid, .pix);
    sbc_src src (.aclk, .aresetn, .slow, .smp_ready, .smp_data, .smp_valid);

    // Free-running 50 MHz clock.
    initial begin
        aclk = 1'b0;
        forever #10 aclk = ~aclk;
    end

    task automatic chk(input string name, input logic [31:0] exp, input logic [31:0] got);
        checked++;
        if (got !== exp) begin
            failures++;
            $display("BAD %s expected %h seen %h", name, exp, got);
        end
    endtask

    task automatic summarize();
        $display("checked %0d failures %0d", checked, failures);
        if (failures == 0 && checked > 0) begin
            $display("STATUS OK");
        end else begin
            $display("STATUS NOT OK");
        end
        $finish;
    endtask

    // Ends the run when a bounded wait ran out.
    task automatic guard(input int n, input int lim);
        if (n >= lim) begin
            failures++;
            $display("BAD wait expected done seen timeout");
            summarize();
        end
    endtask

    // Write with address and data offered together, each released once taken.
    task automatic axw(input logic [7:0] a, input logic [31:0] d, input logic [3:0] s,
                       input logic [1:0] er);
        int n;
        n = 0;
        @(posedge aclk);
        s_axi_awaddr <= a;
        s_axi_awvalid <= 1'b1;
        s_axi_wdata <= d;
        s_axi_wstrb <= s;
        s_axi_wvalid <= 1'b1;
        s_axi_bready <= 1'b1;
        do begin
            @(posedge aclk);
            n++;
            if (s_axi_awready) s_axi_awvalid <= 1'b0;
            if (s_axi_wready) s_axi_wvalid <= 1'b0;
        end while (!s_axi_bvalid && n < 200);
        s_axi_bready <= 1'b0;
        guard(n, 200);
        chk("bresp", {30'h0, er}, {30'h0, s_axi_bresp});
    endtask

    task automatic axr(input logic [7:0] a, input logic [1:0] er, output logic [31:0] d);
        int n;
        n = 0;
        @(posedge aclk);
        s_axi_araddr <= a;
        s_axi_arvalid <= 1'b1;
        s_axi_rready <= 1'b1;
        do begin
            @(posedge aclk);
            n++;
            if (s_axi_arready) s_axi_arvalid <= 1'b0;
        end while (!s_axi_rvalid && n < 200);
        s_axi_rready <= 1'b0;
        guard(n, 200);
        d = s_axi_rdata;
        chk("rresp", {30'h0, er}, {30'h0, s_axi_rresp});
    endtask

    // Collects each bitmap; pixels must come in address order with no gap in the count.
    always @(posedge aclk) begin
        if (!aresetn) begin
            pix_idx = 0;
        end else if (pix_valid) begin
            chk("pix_addr", pix_idx, {24'h0, pix.addr});
            seen[pix.addr] = {pix.transp, pix.rgb};
            pix_idx++;
            if (pix_idx == 256) begin
                frames_seen++;
                pix_idx = 0;
            end
        end
    end

    task automatic wait_frame();
        int n, f;
        n = 0;
        f = frames_seen;
        while (frames_seen == f && n < 3000) begin
            @(posedge aclk);
            n++;
        end
        guard(n, 3000);
    endtask

    // Zero samples put every column in row 0, so only row 0 cells may be lit.
    task automatic chk_frame(input logic [24:0] e0);
        for (int i = 0; i < 256; i++) begin
            chk("pixel", {7'h0, (i % 16 == 0) ? e0 : 25'h0}, {7'h0, seen[i]});
        end
    endtask

    // Settings take effect at once, even mid-conversion, so one whole frame is skipped.
    task automatic cfg(input logic [31:0] c, input logic [31:0] mn, input logic [31:0] mx);
        axw(A_CTRL, c, 4'hF, RESP_OK);
        axw(A_MIN, mn, 4'hF, RESP_OK);
        axw(A_MAX, mx, 4'hF, RESP_OK);
        wait_frame();
        wait_frame();
        axr(A_WAVES, RESP_OK, w_cnt);
    endtask

    task automatic fin(input string name);
        $display("test %s done failures %0d", name, failures);
    endtask

    initial begin
        aresetn = 1'b0;
        slow = 1'b0;
        {s_axi_awaddr, s_axi_araddr, s_axi_wdata, s_axi_wstrb} = '0;
        {s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready} = '0;
        failures = 0;
        checked = 0;
        frames_seen = 0;
        repeat (4) @(posedge aclk);
        aresetn <= 1'b1;
        axr(A_CTRL, RESP_OK, rd);
        chk("ctrl_rst", {26'h0, CTRL_RST}, rd);
        axr(A_MIN, RESP_OK, rd);
        chk("min_rst", {16'h0, MIN_RST}, rd);
        axr(A_MAX, RESP_OK, rd);
        chk("max_rst", {16'h0, MAX_RST}, rd);
        axr(A_FRAMES, RESP_OK, rd);
        chk("frames_rst", 32'h0, rd);
        axr(8'h18, RESP_ERR, rd);
        chk("unmapped_rd", 32'h0, rd);
        axw(8'h18, 32'h5, 4'hF, RESP_ERR);
        axw(A_MIN, 32'h7, 4'h3, RESP_OK);
        axw(A_CTRL, 32'h31, 4'hF, RESP_OK);
        axr(A_CTRL, RESP_OK, rd);
        chk("ctrl_rbw", 32'h31, rd);
        axr(A_MIN, RESP_OK, rd);
        chk("min_strb", 32'h1, rd);
        fin("registers");
        cfg(32'h01, 32'h1, 32'h9);
        chk("waves", 32'h1, {31'h0, w_cnt > 9 && w_cnt <= {16'h0, WAVE_MAX}});
        chk_frame({1'b1, 24'hC00000});
        fin("default_map");
        cfg(32'h01, 32'h1, 32'd1000);
        chk_frame({1'b0, 24'h000080});
        fin("wide_max");
        slow <= 1'b1;
        cfg(32'h01, 32'd2000, 32'd3000);
        chk_frame(25'h0);
        fin("below_min");
        cfg(32'h35, 32'h1, 32'h9);
        chk_frame({1'b0, 24'hC00000});
        slow <= 1'b0;
        cfg(32'h07, 32'h1, 32'h9);
        chk_frame({1'b0, 24'h999999});
        fin("full_scale");
        cfg(32'h00, 32'h1, 32'h9);
        chk("smp_ready", 32'h0, {31'h0, smp_ready});
        chk("waves_off", 32'h0, w_cnt);
        chk_frame(25'h0);
        fin("disabled");
        axw(A_CTRL, 32'h01, 4'hF, RESP_OK);
        wait_frame();
        axw(A_CTRL, 32'h09, 4'hF, RESP_OK);
        wait_frame();
        axr(A_PEAK, RESP_OK, peak);
        axr(A_WAVES, RESP_OK, w_cnt);
        axr(A_MAX, RESP_OK, rd);
        chk("auto_max", peak, rd);
        chk("peak", w_cnt, peak);
        axr(A_CTRL, RESP_OK, rd);
        chk("auto_clear", 32'h01, rd);
        axr(A_FRAMES, RESP_OK, rd);
        chk("frames", frames_seen, rd);
        fin("auto_colour");
        summarize();
    end
endmodule
